/* hdl/supply_fault_irq.sv */
// What this block does
// - ten under-voltage flags, rising-edge set
// - flags sticky, cleared by reading register
// - 10-bit under-voltage mask gates summary
// - all mask bits zero after reset
// - two current-sink flags, bits 13:12
// - current-sink mask bits 13:12 gate summary
// - three supply-change flags, bits 15:13
// - supply flags set on either edge
// - supply mask bits 15:13 gate summary
// - summary is OR of unmasked flags
// - masked flags still set normally
`timescale 1ns/1ns
module supply_fault_irq
(
    input  wire logic                              mclk,
    input  wire logic                              reset,
    input  wire supply_irq_pkg::reg_req_type       reg_req,
    output logic [supply_irq_pkg::REG_W-1:0]       reg_rdata,
    input  wire logic [supply_irq_pkg::LINREG_N-1:0]    linreg_undervoltage,
    input  wire logic [supply_irq_pkg::BUCKBOOST_N-1:0] buckboost_undervoltage,
    input  wire logic [supply_irq_pkg::SINK_N-1:0]      sink_regulation_lost,
    input  wire logic                              usb_supply_status,
    input  wire logic                              adaptor_supply_status,
    input  wire logic                              battery_supply_status,
    output logic                                   undervoltage_summary_flag,
    output logic                                   current_sink_summary_flag,
    output logic                                   external_supply_summary_flag
);
    import supply_irq_pkg::*;

    logic [REG_W-1:0] events   [GRP_N];
    logic [REG_W-1:0] status   [GRP_N];
    logic [REG_W-1:0] mask_ff  [GRP_N];
    logic [REG_W-1:0] unmasked [GRP_N];
    logic [GRP_N-1:0] clear_rd;
    logic [REG_W-1:0] nxt_rdata;
    logic [REG_W-1:0] rdata_ff;
    logic [GRP_N-1:0] summary_ff;

    localparam logic [REG_W-1:0] FIELD    [GRP_N] = '{UV_FIELD, CS_FIELD,
                                                      EXT_FIELD};
    localparam logic [GRP_N-1:0] BOTH_EDG = 3'h4;

    // gather event inputs into status bit positions
    always_comb
    begin
        events[GRP_UV]  = '0;
        events[GRP_CS]  = '0;
        events[GRP_EXT] = '0;
        events[GRP_UV][UV_LINREG_LSB +: LINREG_N]  = linreg_undervoltage;
        events[GRP_UV][UV_BUCK_LSB +: BUCKBOOST_N] = buckboost_undervoltage;
        events[GRP_CS][CS_LSB +: SINK_N]           = sink_regulation_lost;
        events[GRP_EXT][EXT_LSB +: SUPPLY_N]       = {usb_supply_status,
                                                      adaptor_supply_status,
                                                      battery_supply_status};
    end

    // a read of a status register clears that register
    assign clear_rd[GRP_UV]  = reg_req.rd_en &&
                               reg_req.addr == UNDERVOLTAGE_IRQ_STATUS;
    assign clear_rd[GRP_CS]  = reg_req.rd_en &&
                               reg_req.addr == CURRENT_SINK_IRQ_STATUS;
    assign clear_rd[GRP_EXT] = reg_req.rd_en &&
                               reg_req.addr == COMPARATOR_IRQ_STATUS;

    // one sticky edge cell per implemented status bit
    for (genvar g = 0; g < GRP_N; g++)
    begin : g_grp
        for (genvar i = 0; i < REG_W; i++)
        begin : g_bit
            if (FIELD[g][i])
            begin : g_cell
                sticky_edge_flag #(.BOTH_EDGES(BOTH_EDG[g])) u_flag
                (
                    .mclk     (mclk),
                    .reset    (reset),
                    .event_in (events[g][i]),
                    .clear    (clear_rd[g]),
                    .flag_ff  (status[g][i])
                );
            end
            else
            begin : g_none
                assign status[g][i] = 1'b0;
            end
        end
        // masking acts only on the summary, never on the flag
        assign unmasked[g] = status[g] & ~mask_ff[g];
    end

    // mask registers, written through the control interface
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mask_ff[GRP_UV]  <= MASK_RESET;
            mask_ff[GRP_CS]  <= MASK_RESET;
            mask_ff[GRP_EXT] <= MASK_RESET;
        end
        else if (reg_req.wr_en)
        begin
            if (reg_req.addr == UNDERVOLTAGE_IRQ_MASK)
                mask_ff[GRP_UV] <= reg_req.wdata & UV_FIELD;
            else if (reg_req.addr == CURRENT_SINK_IRQ_MASK)
                mask_ff[GRP_CS] <= reg_req.wdata & CS_FIELD;
            else if (reg_req.addr == COMPARATOR_IRQ_MASK)
                mask_ff[GRP_EXT] <= reg_req.wdata & EXT_FIELD;
        end
    end

    // read multiplexer, unmapped addresses read zero
    always_comb
    begin
        if (reg_req.addr == UNDERVOLTAGE_IRQ_STATUS)
            nxt_rdata = status[GRP_UV];
        else if (reg_req.addr == CURRENT_SINK_IRQ_STATUS)
            nxt_rdata = status[GRP_CS];
        else if (reg_req.addr == COMPARATOR_IRQ_STATUS)
            nxt_rdata = status[GRP_EXT];
        else if (reg_req.addr == UNDERVOLTAGE_IRQ_MASK)
            nxt_rdata = mask_ff[GRP_UV];
        else if (reg_req.addr == CURRENT_SINK_IRQ_MASK)
            nxt_rdata = mask_ff[GRP_CS];
        else if (reg_req.addr == COMPARATOR_IRQ_MASK)
            nxt_rdata = mask_ff[GRP_EXT];
        else
            nxt_rdata = '0;
    end

    // read data register, holds until the next read
    always_ff @(posedge mclk)
    begin
        if (reset)
            rdata_ff <= '0;
        else if (reg_req.rd_en)
            rdata_ff <= nxt_rdata;
    end

    // first-level summaries
    always_ff @(posedge mclk)
    begin
        if (reset)
            summary_ff <= '0;
        else
        begin
            summary_ff[GRP_UV]  <= |unmasked[GRP_UV];
            summary_ff[GRP_CS]  <= |unmasked[GRP_CS];
            summary_ff[GRP_EXT] <= |unmasked[GRP_EXT];
        end
    end

    assign reg_rdata                    = rdata_ff;
    assign undervoltage_summary_flag    = summary_ff[GRP_UV];
    assign current_sink_summary_flag    = summary_ff[GRP_CS];
    assign external_supply_summary_flag = summary_ff[GRP_EXT];

    // checks
    a_uv_rise_sets: assert property (@(posedge mclk) disable iff (reset)
        $rose(linreg_undervoltage[0]) |=> status[GRP_UV][UV_LINREG_LSB])
        else $error("linreg rising edge did not set its flag");

    a_set_beats_clear: assert property (@(posedge mclk)
        disable iff (reset)
        $rose(buckboost_undervoltage[0]) && clear_rd[GRP_UV]
        |=> status[GRP_UV][UV_BUCK_LSB])
        else $error("edge lost against clearing read");

    a_read_clears: assert property (@(posedge mclk) disable iff (reset)
        clear_rd[GRP_UV] && $stable(linreg_undervoltage)
        && $stable(buckboost_undervoltage) |=> status[GRP_UV] == '0)
        else $error("read did not clear under-voltage flags");

    a_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
        status[GRP_CS][CS_LSB] && !clear_rd[GRP_CS]
        |=> status[GRP_CS][CS_LSB] [*1])
        else $error("current-sink flag dropped without a read");

    a_cs_rise_sets: assert property (@(posedge mclk) disable iff (reset)
        $rose(sink_regulation_lost[1]) |=> status[GRP_CS][CS_LSB+1])
        else $error("sink one flag not set");

    a_ext_fall_sets: assert property (@(posedge mclk) disable iff (reset)
        $fell(usb_supply_status) |=> status[GRP_EXT][EXT_LSB+2])
        else $error("falling supply change not flagged");

    a_masks_reset: assert property (@(posedge mclk)
        $fell(reset) |-> mask_ff[GRP_UV] == '0 && mask_ff[GRP_CS] == '0
        && mask_ff[GRP_EXT] == '0)
        else $error("mask not zero after reset");

    a_uv_summary: assert property (@(posedge mclk) disable iff (reset)
        ##1 undervoltage_summary_flag == $past(|unmasked[GRP_UV]))
        else $error("under-voltage summary wrong");

    a_ext_masked: assert property (@(posedge mclk) disable iff (reset)
        mask_ff[GRP_EXT] == EXT_FIELD |=> !external_supply_summary_flag)
        else $error("masked supply flags reached summary");

    a_read_data: assert property (@(posedge mclk) disable iff (reset)
        reg_req.rd_en && reg_req.addr == COMPARATOR_IRQ_STATUS
        |=> reg_rdata == $past(status[GRP_EXT]))
        else $error("comparator status read data wrong");
endmodule // supply_fault_irq

/* inc/supply_irq_pkg.sv */
package supply_irq_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int REG_W  = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] CURRENT_SINK_IRQ_STATUS = 8'h1A;
    localparam logic [ADDR_W-1:0] UNDERVOLTAGE_IRQ_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] COMPARATOR_IRQ_STATUS   = 8'h1F;
    localparam logic [ADDR_W-1:0] CURRENT_SINK_IRQ_MASK   = 8'h22;
    localparam logic [ADDR_W-1:0] UNDERVOLTAGE_IRQ_MASK   = 8'h24;
    localparam logic [ADDR_W-1:0] COMPARATOR_IRQ_MASK     = 8'h27;

    // field positions and sizes
    localparam int LINREG_N      = 4;
    localparam int BUCKBOOST_N   = 6;
    localparam int SINK_N        = 2;
    localparam int SUPPLY_N      = 3;
    localparam int UV_LINREG_LSB = 8;
    localparam int UV_BUCK_LSB   = 0;
    localparam int CS_LSB        = 12;
    localparam int EXT_LSB       = 13;

    // implemented bits of each status/mask register
    localparam logic [REG_W-1:0] UV_FIELD  = 16'h0F3F;
    localparam logic [REG_W-1:0] CS_FIELD  = 16'h3000;
    localparam logic [REG_W-1:0] EXT_FIELD = 16'hE000;
    localparam logic [REG_W-1:0] MASK_RESET = 16'h0000;

    // group indices
    localparam int GRP_UV  = 0;
    localparam int GRP_CS  = 1;
    localparam int GRP_EXT = 2;
    localparam int GRP_N   = 3;

    // one register access from the control interface
    typedef struct packed {
        logic              rd_en;
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
    } reg_req_type;

endpackage

/* hdl/sticky_edge_flag.sv */
`timescale 1ns/1ns
module sticky_edge_flag
#(
    parameter bit BOTH_EDGES = 1'b0
)
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic event_in,
    input  wire logic clear,
    output logic      flag_ff
);
    logic prev_ff;
    logic edge_seen;

    // previous event level, loaded during reset so no false edge
    always_ff @(posedge mclk)
    begin
        prev_ff <= event_in;
    end

    // rising edge, or any change when both edges count
    assign edge_seen = BOTH_EDGES ? (event_in ^ prev_ff)
                                  : (event_in & ~prev_ff);

    // sticky flag: new edge beats a clearing read
    always_ff @(posedge mclk)
    begin
        if (reset)
            flag_ff <= 1'b0;
        else if (edge_seen)
            flag_ff <= 1'b1;
        else if (clear)
            flag_ff <= 1'b0;
    end
endmodule // sticky_edge_flag

/* tb/supply_host_model.sv */
`timescale 1ns/1ns
module supply_host_model
(
    input  wire logic                   mclk,
    output supply_irq_pkg::reg_req_type reg_req,
    output logic                        rd_seen
);
    import supply_irq_pkg::*;
    // idle bus from time zero
    initial reg_req = '0;
    // marks an edge that took a read
    always @(posedge mclk)
        rd_seen <= reg_req.rd_en;
    // read strobe held over one rising edge
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(negedge mclk);
        reg_req.addr  = a;
        reg_req.rd_en = 1'b1;
        @(negedge mclk);
        reg_req.rd_en = 1'b0;
    endtask
    // write strobe held over one rising edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(negedge mclk);
        reg_req.addr  = a;
        reg_req.wdata = d;
        reg_req.wr_en = 1'b1;
        @(negedge mclk);
        reg_req.wr_en = 1'b0;
    endtask
endmodule // supply_host_model

/* tb/supply_fault_irq_bench.sv */
`timescale 1ns/1ns
module supply_fault_irq_bench;
    import supply_irq_pkg::*;
    logic                   mclk = 1'b0;
    logic                   reset = 1'b1;
    reg_req_type            reg_req;
    logic [REG_W-1:0]       reg_rdata;
    logic [LINREG_N-1:0]    lin = '0;
    logic [BUCKBOOST_N-1:0] bck = '0;
    logic [SINK_N-1:0]      snk = '0;
    logic                   usb = 1'b0;
    logic                   adp = 1'b0;
    logic                   bat = 1'b0;
    logic                   uv_sum;
    logic                   cs_sum;
    logic                   ext_sum;
    logic                   rd_seen;
    logic [REG_W-1:0]       exp_q[$];
    logic [31:0]            seed = 32'd79585;
    logic [9:0]             v;
    int                     err_count = 0;
    int                     checked = 0;
    // 20 MHz clock
    always #25 mclk = ~mclk;
    supply_fault_irq i_dut (.mclk(mclk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .linreg_undervoltage(lin),
        .buckboost_undervoltage(bck), .sink_regulation_lost(snk),
        .usb_supply_status(usb), .adaptor_supply_status(adp),
        .battery_supply_status(bat), .undervoltage_summary_flag(uv_sum),
        .current_sink_summary_flag(cs_sum),
        .external_supply_summary_flag(ext_sum));
    supply_host_model i_host (.mclk(mclk), .reg_req(reg_req),
        .rd_seen(rd_seen));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [REG_W-1:0] g, e, input string w);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %0t: %s got %h want %h", $time, w, g, e);
        end
    endtask
    // note the expected word, then read
    task automatic rx(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
        exp_q.push_back(e);
        i_host.rd(a);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // compares each read word with the oldest note
    always @(negedge mclk)
        if (rd_seen === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(reg_rdata, 16'hXXXX, "unexpected read");
            else
                chk(reg_rdata, exp_q.pop_front(), "read");
        end
    // hang guard, far beyond the run length
    initial
    begin
        #(2000 * 50);
        err_count++;
        $display("Error %0t: timeout", $time);
        print_verdict();
    end
    initial
    begin
        idle(5);
        reset = 1'b0;
        rx(CURRENT_SINK_IRQ_MASK, MASK_RESET);
        rx(UNDERVOLTAGE_IRQ_MASK, MASK_RESET);
        rx(COMPARATOR_IRQ_MASK, MASK_RESET);
        $display("test reset done");
        seed = lfsr(seed);
        v = seed[9:0] | 10'h001;
        lin = v[9:6];
        bck = v[5:0];
        idle(3);
        chk(16'(uv_sum), 16'h0001, "uv sum");
        rx(UNDERVOLTAGE_IRQ_STATUS, {4'h0, v[9:6], 2'b00, v[5:0]});
        rx(UNDERVOLTAGE_IRQ_STATUS, 16'h0000);
        lin = '0;
        bck = '0;
        idle(3);
        chk(16'(uv_sum), 16'h0000, "uv sum");
        rx(UNDERVOLTAGE_IRQ_STATUS, 16'h0000);
        seed = lfsr(seed);
        i_host.wr(UNDERVOLTAGE_IRQ_MASK, seed[15:0]);
        rx(UNDERVOLTAGE_IRQ_MASK, seed[15:0] & UV_FIELD);
        i_host.wr(UNDERVOLTAGE_IRQ_MASK, UV_FIELD);
        lin = '1;
        bck = '1;
        idle(3);
        chk(16'(uv_sum), 16'h0000, "uv masked");
        rx(UNDERVOLTAGE_IRQ_STATUS, UV_FIELD);
        i_host.wr(UNDERVOLTAGE_IRQ_MASK, 16'h0000);
        lin = '0;
        bck = '0;
        fork
            rx(UNDERVOLTAGE_IRQ_STATUS, 16'h0000);
            begin
                @(negedge mclk);
                {lin[0], bck[0]} = 2'b11;
            end
        join
        rx(UNDERVOLTAGE_IRQ_STATUS, 16'h0101);
        $display("test undervoltage done");
        snk = 2'b11;
        idle(3);
        chk(16'(cs_sum), 16'h0001, "cs sum");
        rx(CURRENT_SINK_IRQ_STATUS, CS_FIELD);
        i_host.wr(CURRENT_SINK_IRQ_MASK, 16'hFFFF);
        rx(CURRENT_SINK_IRQ_MASK, CS_FIELD);
        snk = 2'b00;
        idle(1);
        snk = 2'b10;
        idle(3);
        chk(16'(cs_sum), 16'h0000, "cs masked");
        rx(CURRENT_SINK_IRQ_STATUS, 16'h2000);
        $display("test sink done");
        {usb, adp, bat} = 3'b111;
        idle(3);
        chk(16'(ext_sum), 16'h0001, "ext sum");
        rx(COMPARATOR_IRQ_STATUS, EXT_FIELD);
        {usb, adp, bat} = 3'b000;
        idle(3);
        rx(COMPARATOR_IRQ_STATUS, EXT_FIELD);
        i_host.wr(COMPARATOR_IRQ_MASK, 16'hFFFF);
        rx(COMPARATOR_IRQ_MASK, EXT_FIELD);
        usb = 1'b1;
        idle(3);
        chk(16'(ext_sum), 16'h0000, "ext masked");
        rx(COMPARATOR_IRQ_STATUS, 16'h8000);
        i_host.wr(COMPARATOR_IRQ_STATUS, 16'hFFFF);
        rx(COMPARATOR_IRQ_STATUS, 16'h0000);
        rx(8'h00, 16'h0000);
        $display("test supply done");
        idle(3);
        chk(16'(exp_q.size()), 16'h0000, "reads left");
        print_verdict();
    end
endmodule // supply_fault_irq_bench
